/* rtl/acdpc_top.v */
// Sample clock divider, duty stabilizer and power control with AXI4-Lite registers
`timescale 1ns/100ps
`include "acdpc_defs.vh"
module acdpc_top #(
    parameter DOWN_W = 12
) (
    // Clock, reset, enable
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    // AXI4-Lite write channels
    input wire [11:0] awaddr_i,
    input wire awvalid_i,
    output reg awready_o,
    input wire [31:0] wdata_i,
    input wire [3:0] wstrb_i,
    input wire wvalid_i,
    output reg wready_o,
    output reg [1:0] bresp_o,
    output reg bvalid_o,
    input wire bready_i,
    // AXI4-Lite read channels
    input wire [11:0] araddr_i,
    input wire arvalid_i,
    output reg arready_o,
    output reg [31:0] rdata_o,
    output reg [1:0] rresp_o,
    output reg rvalid_o,
    input wire rready_i,
    // Pins from the board
    input wire sync_i,
    input wire power_down_pin_i,
    input wire sense_hi_i,
    // Clock outputs
    output wire div_clk_o,
    output wire sample_o,
    output reg dcs_locked_o,
    // Analog enables
    output reg ref_int_en_o,
    output reg ref_ext_sel_o,
    output reg ref_buf_en_o,
    output reg bias_en_o,
    output reg int_clk_en_o,
    output reg out_oe_o,
    output reg dev_ready_o
);
    localparam integer LOCK_CYC = `ACDPC_DCS_LOCK_CYC;

    // Clamp a written ratio into the legal one-to-six range
    function [2:0] clamp_ratio;
        input [2:0] r;
        begin
            if (r < `ACDPC_RATIO_MIN) begin
                clamp_ratio = `ACDPC_RATIO_MIN;
            end else if (r > `ACDPC_RATIO_MAX) begin
                clamp_ratio = `ACDPC_RATIO_MAX;
            end else begin
                clamp_ratio = r;
            end
        end
    endfunction

    // Divided rate high enough for the stabilizer loop to operate
    function rate_ok;
        input [2:0] r;
        begin
            rate_ok = ({29'h0, r} * `ACDPC_DCS_MIN_MHZ) <= `ACDPC_CLK_MHZ;
        end
    endfunction

    // Configuration registers
    reg [2:0] ratio;
    reg dcs_en;
    reg pd_reg;
    reg sb_reg;
    reg [1:0] sync_mode;
    reg sync_armed;

    // Pin synchronisers: three stages each
    wire [2:0] pin_raw;
    reg [2:0] pin_s1;
    reg [2:0] pin_s2;
    reg [2:0] pin_s3;
    reg [2:0] pin_lvl;

    assign pin_raw = {sense_hi_i, power_down_pin_i, sync_i};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
            // A change counts once the second and third stages agree
            always @(posedge mclk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    pin_s3[gi] <= 1'b0;
                    pin_lvl[gi] <= 1'b0;
                end else if (ce_i) begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi]) begin
                        pin_lvl[gi] <= pin_s3[gi];
                    end
                end
            end
        end
    endgenerate

    // Sync edge and acceptance under the selected mode
    reg sync_prev;
    wire sync_rise;
    wire sync_hit;
    wire [1:0] pwr_state;
    wire running;

    assign sync_rise = pin_lvl[0] & ~sync_prev;
    assign running = (pwr_state == `ACDPC_PWR_RUN);
    // Mode bit selects every pulse, once bit limits to first after write
    assign sync_hit = sync_rise & running & sync_mode[0]
        & (~sync_mode[1] | sync_armed);

    // AXI write path: address and data taken in either order
    reg aw_held;
    reg w_held;
    reg [11:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    wire wr_go;
    wire wr_clk;
    wire wr_pwr;
    wire wr_sync;

    assign wr_go = aw_held & w_held & ~bvalid_o;
    assign wr_clk = wr_go & (aw_addr[11:2] == `ACDPC_ADDR_CLK >> 2);
    assign wr_pwr = wr_go & (aw_addr[11:2] == `ACDPC_ADDR_PWR >> 2);
    assign wr_sync = wr_go & (aw_addr[11:2] == `ACDPC_ADDR_SYNC >> 2);

    // Write channel handshakes and response
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            awready_o <= 1'b1;
            wready_o <= 1'b1;
            bvalid_o <= 1'b0;
            bresp_o <= `ACDPC_RESP_OKAY;
        end else if (ce_i) begin
            if (awvalid_i && awready_o) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr_i;
                awready_o <= 1'b0;
            end
            if (wvalid_i && wready_o) begin
                w_held <= 1'b1;
                w_data <= wdata_i;
                w_strb <= wstrb_i;
                wready_o <= 1'b0;
            end
            if (wr_go) begin
                bvalid_o <= 1'b1;
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bresp_o <= (wr_clk | wr_pwr | wr_sync
                    | (aw_addr[11:2] == `ACDPC_ADDR_STAT >> 2))
                    ? `ACDPC_RESP_OKAY : `ACDPC_RESP_SLVERR;
            end
            // Channels reopen only after the response is taken
            if (bvalid_o && bready_i) begin
                bvalid_o <= 1'b0;
                awready_o <= 1'b1;
                wready_o <= 1'b1;
            end
        end
    end

    // Register storage; only the low byte carries fields
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ratio <= `ACDPC_RATIO_RST;
            dcs_en <= `ACDPC_DCS_RST;
            pd_reg <= 1'b0;
            sb_reg <= 1'b0;
            sync_mode <= `ACDPC_SYNC_RST;
            sync_armed <= 1'b0;
            sync_prev <= 1'b0;
        end else if (ce_i) begin
            sync_prev <= pin_lvl[0];
            if (wr_clk && w_strb[0]) begin
                ratio <= clamp_ratio(w_data[`ACDPC_CLK_RATIO_LSB +: 3]);
                dcs_en <= w_data[`ACDPC_CLK_DCS_BIT];
            end
            if (wr_pwr && w_strb[0]) begin
                pd_reg <= w_data[`ACDPC_PWR_PD_BIT];
                sb_reg <= w_data[`ACDPC_PWR_SB_BIT];
            end
            // A write rearms single-shot mode; it wins over a same-cycle sync
            if (wr_sync && w_strb[0]) begin
                sync_mode <= w_data[`ACDPC_SYNC_ONCE_BIT:`ACDPC_SYNC_EN_BIT];
                sync_armed <= 1'b1;
            end else if (sync_hit) begin
                sync_armed <= 1'b0;
            end
        end
    end

    // Read path: one request at a time, answer one cycle later
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arready_o <= 1'b1;
            rvalid_o <= 1'b0;
            rdata_o <= 32'h00000000;
            rresp_o <= `ACDPC_RESP_OKAY;
        end else if (ce_i) begin
            if (arvalid_i && arready_o) begin
                arready_o <= 1'b0;
                rvalid_o <= 1'b1;
                rresp_o <= `ACDPC_RESP_OKAY;
                case (araddr_i[11:2])
                    `ACDPC_ADDR_CLK >> 2: begin
                        rdata_o <= {27'h0, dcs_en, 1'b0, ratio};
                    end
                    `ACDPC_ADDR_PWR >> 2: begin
                        rdata_o <= {30'h0, sb_reg, pd_reg};
                    end
                    `ACDPC_ADDR_SYNC >> 2: begin
                        rdata_o <= {29'h0, sync_mode, 1'b0};
                    end
                    `ACDPC_ADDR_STAT >> 2: begin
                        rdata_o <= {25'h0, sync_armed, dev_ready_o, ref_ext_sel_o,
                            pwr_state, pin_lvl[1], dcs_locked_o};
                    end
                    default: begin
                        rdata_o <= 32'h00000000;
                        rresp_o <= `ACDPC_RESP_SLVERR;
                    end
                endcase
            end
            if (rvalid_o && rready_i) begin
                rvalid_o <= 1'b0;
                arready_o <= 1'b1;
            end
        end
    end

    // Power state sequencer; pin and register requests combine
    acdpc_pwr #(
        .DOWN_W(DOWN_W)
    ) u_pwr (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .pd_i(pin_lvl[1] | pd_reg),
        .sb_i(sb_reg),
        .state_o(pwr_state)
    );

    // Stabilizer only engages where the divided rate supports its loop
    wire dcs_act;
    assign dcs_act = dcs_en & rate_ok(ratio);

    acdpc_div u_div (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .run_i(running),
        .ratio_i(ratio),
        .dcs_i(dcs_act),
        .restart_i(sync_hit),
        .div_clk_o(div_clk_o),
        .rise_o(sample_o)
    );

    // Relock timer restarts on any change of the divided rate or duty mode
    reg [11:0] lock_cnt;
    reg [2:0] lock_ratio;
    reg lock_dcs;

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_cnt <= 12'h000;
            lock_ratio <= `ACDPC_RATIO_RST;
            lock_dcs <= 1'b0;
            dcs_locked_o <= 1'b0;
        end else if (ce_i) begin
            lock_ratio <= ratio;
            lock_dcs <= dcs_act;
            if (!dcs_act || !running || lock_ratio != ratio || !lock_dcs) begin
                lock_cnt <= 12'h000;
                dcs_locked_o <= 1'b0;
            end else if (lock_cnt < LOCK_CYC) begin
                lock_cnt <= lock_cnt + 12'h001;
            end else begin
                dcs_locked_o <= 1'b1;
            end
        end
    end

    // Analog enables; standby keeps the reference alive, down stops all
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_int_en_o <= 1'b0;
            ref_ext_sel_o <= 1'b0;
            ref_buf_en_o <= 1'b0;
            bias_en_o <= 1'b0;
            int_clk_en_o <= 1'b0;
            out_oe_o <= 1'b0;
            dev_ready_o <= 1'b0;
        end else if (ce_i) begin
            ref_ext_sel_o <= pin_lvl[2];
            ref_int_en_o <= ~pin_lvl[2] & (pwr_state != `ACDPC_PWR_DOWN);
            ref_buf_en_o <= (pwr_state != `ACDPC_PWR_DOWN);
            bias_en_o <= (pwr_state != `ACDPC_PWR_DOWN);
            int_clk_en_o <= running;
            out_oe_o <= running;
            dev_ready_o <= running;
        end
    end
endmodule // acdpc_top

/* rtl/acdpc_defs.vh */
// Constants for the converter clock divider and power control block
`ifndef ACDPC_DEFS_VH
`define ACDPC_DEFS_VH
// Register byte offsets
`define ACDPC_ADDR_CLK 12'h000
`define ACDPC_ADDR_PWR 12'h008
`define ACDPC_ADDR_STAT 12'h010
`define ACDPC_ADDR_SYNC 12'h100
// Field positions
`define ACDPC_CLK_RATIO_LSB 0
`define ACDPC_CLK_DCS_BIT 4
`define ACDPC_PWR_PD_BIT 0
`define ACDPC_PWR_SB_BIT 1
`define ACDPC_SYNC_EN_BIT 1
`define ACDPC_SYNC_ONCE_BIT 2
// Reset values
`define ACDPC_RATIO_RST 3'h1
`define ACDPC_DCS_RST 1'b0
`define ACDPC_SYNC_RST 2'h0
// Divide ratio limits
`define ACDPC_RATIO_MIN 3'h1
`define ACDPC_RATIO_MAX 3'h6
// Power states
`define ACDPC_PWR_RUN 2'h0
`define ACDPC_PWR_SB 2'h1
`define ACDPC_PWR_DOWN 2'h2
`define ACDPC_PWR_WAKE 2'h3
// AXI responses
`define ACDPC_RESP_OKAY 2'h0
`define ACDPC_RESP_SLVERR 2'h2
// Timing
`define ACDPC_CLK_MHZ 100
`define ACDPC_DCS_MIN_MHZ 20
`define ACDPC_DCS_LOCK_NS 1500
`define ACDPC_DCS_LOCK_CYC ((`ACDPC_DCS_LOCK_NS * `ACDPC_CLK_MHZ + 999) / 1000)
`define ACDPC_SB_WAKE_CYC 4
`define ACDPC_WAKE_SHIFT 3
`endif

/* rtl/acdpc_div.v */
// Integer clock divider with optional even duty regeneration
`timescale 1ns/100ps
`include "acdpc_defs.vh"
module acdpc_div (
    // Clock and control
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    input wire run_i,
    // Configuration, latched only at a wrap or a restart
    input wire [2:0] ratio_i,
    input wire dcs_i,
    input wire restart_i,
    // Divided clock and sample strobe
    output reg div_clk_o,
    output reg rise_o
);
    reg [2:0] cnt;
    reg [2:0] act_ratio;
    reg act_dcs;
    wire [2:0] hi_len;
    wire [2:0] cnt_nx;

    // High time with the stabilizer: half the period, odd ratios round up
    assign hi_len = act_ratio[2:1] + {2'h0, act_ratio[0]};
    assign cnt_nx = cnt + 3'h1;

    // New ratio and duty mode load only at a wrap or a restart, so no runt pulse
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= 3'h0;
            act_ratio <= `ACDPC_RATIO_RST;
            act_dcs <= `ACDPC_DCS_RST;
            div_clk_o <= 1'b0;
            rise_o <= 1'b0;
        end else if (ce_i) begin
            if (!run_i) begin
                // Park at the wrap point so resuming restarts with a strobe
                cnt <= act_ratio - 3'h1;
                div_clk_o <= 1'b0;
                rise_o <= 1'b0;
            end else if (restart_i || cnt_nx >= act_ratio) begin
                cnt <= 3'h0;
                act_ratio <= ratio_i;
                act_dcs <= dcs_i;
                div_clk_o <= 1'b1; // Rising edge stays on the count start
                rise_o <= 1'b1;
            end else begin
                cnt <= cnt_nx;
                rise_o <= 1'b0;
                // Without the stabilizer the high time is one input cycle
                div_clk_o <= act_dcs & (cnt_nx < hi_len);
            end
        end
    end
endmodule // acdpc_div

/* rtl/acdpc_pwr.v */
// Power state sequencer with wake time tracking time spent down
`timescale 1ns/100ps
`include "acdpc_defs.vh"
module acdpc_pwr #(
    parameter DOWN_W = 12
) (
    // Clock and control
    input wire mclk_i,
    input wire rstn_i,
    input wire ce_i,
    // Requests
    input wire pd_i,
    input wire sb_i,
    // State
    output reg [1:0] state_o
);
    reg [DOWN_W-1:0] down_cnt;
    reg [DOWN_W-1:0] wake_cnt;
    localparam [31:0] SB_WAKE = `ACDPC_SB_WAKE_CYC;

    // Down time saturates so a very long sleep still wakes in bounded time
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_o <= `ACDPC_PWR_RUN;
            down_cnt <= {DOWN_W{1'b0}};
            wake_cnt <= {DOWN_W{1'b0}};
        end else if (ce_i) begin
            case (state_o)
                `ACDPC_PWR_RUN: begin
                    down_cnt <= {DOWN_W{1'b0}};
                    if (pd_i) begin
                        state_o <= `ACDPC_PWR_DOWN;
                    end else if (sb_i) begin
                        state_o <= `ACDPC_PWR_SB;
                    end
                end
                `ACDPC_PWR_SB: begin
                    if (pd_i) begin
                        state_o <= `ACDPC_PWR_DOWN;
                    end else if (!sb_i) begin
                        state_o <= `ACDPC_PWR_WAKE;
                        // Reference stayed up, so wake is short and fixed
                        wake_cnt <= SB_WAKE[DOWN_W-1:0];
                    end
                end
                `ACDPC_PWR_DOWN: begin
                    if (!down_cnt[DOWN_W-1] || down_cnt != {DOWN_W{1'b1}}) begin
                        down_cnt <= down_cnt + {{(DOWN_W-1){1'b0}}, 1'b1};
                    end
                    if (!pd_i) begin
                        state_o <= `ACDPC_PWR_WAKE;
                        wake_cnt <= (down_cnt >> `ACDPC_WAKE_SHIFT)
                            + {{(DOWN_W-1){1'b0}}, 1'b1};
                    end
                end
                `ACDPC_PWR_WAKE: begin
                    if (pd_i) begin
                        state_o <= `ACDPC_PWR_DOWN;
                        down_cnt <= {DOWN_W{1'b0}};
                    end else if (wake_cnt <= {{(DOWN_W-1){1'b0}}, 1'b1}) begin
                        state_o <= `ACDPC_PWR_RUN;
                    end else begin
                        wake_cnt <= wake_cnt - {{(DOWN_W-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    state_o <= `ACDPC_PWR_RUN;
                end
            endcase
        end
    end
endmodule // acdpc_pwr

/* testbench/acdpc_chk.sv */
// Port checker for the sample clock divider and power control block
`timescale 1ns/100ps
module acdpc_chk (
    // Clock and reset
    input wire mclk_i,
    input wire rstn_i,
    // Bus handshakes
    input wire awvalid_i, input wire awready_o, input wire wvalid_i, input wire wready_o,
    input wire bvalid_o, input wire arvalid_i, input wire arready_o, input wire rvalid_o,
    // Pins and outputs
    input wire power_down_pin_i, input wire div_clk_o, input wire sample_o,
    input wire ref_int_en_o, input wire ref_ext_sel_o, input wire ref_buf_en_o,
    input wire bias_en_o, input wire int_clk_en_o, input wire out_oe_o, input wire dev_ready_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    // Cycles since the last strobe; cleared outside run so wake-up gaps are not judged
    reg [3:0] gap;
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i)
            gap <= 4'h0;
        else if (sample_o || !dev_ready_o)
            gap <= 4'h0;
        else
            gap <= gap + 4'h1;
    end
    AST_PERIOD: assert property (gap <= 4'h5)
        else $error("divided clock period above six cycles");
    AST_SAMPLE_HIGH: assert property (sample_o |-> div_clk_o)
        else $error("sample strobe while divided clock low");
    AST_RISE_SAMPLE: assert property ($rose(div_clk_o) |-> sample_o)
        else $error("divided clock rose without a sample strobe");
    AST_PIN_DOWN: assert property (power_down_pin_i [*8] |=> !out_oe_o && !int_clk_en_o)
        else $error("pin held high but device still running");
    AST_OE_READY: assert property (out_oe_o == dev_ready_o)
        else $error("output drivers enabled outside run");
    AST_DOWN_OFF: assert property (!ref_buf_en_o |-> !(bias_en_o || int_clk_en_o || ref_int_en_o || out_oe_o))
        else $error("block left on while reference buffer off");
    AST_BIAS_BUF: assert property (ref_buf_en_o == bias_en_o)
        else $error("bias and reference buffer disagree");
    AST_EXT_REF: assert property (ref_ext_sel_o |-> !ref_int_en_o)
        else $error("internal reference on with external selected");
    AST_WR_RESP: assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##[1:2] bvalid_o)
        else $error("write response missing");
    AST_RD_RESP: assert property (arvalid_i && arready_o |-> ##[1:2] rvalid_o)
        else $error("read data missing");
    AST_B_BLOCK: assert property (bvalid_o |-> !awready_o && !wready_o)
        else $error("write accepted while response pending");
endmodule // acdpc_chk
bind acdpc_top acdpc_chk u_acdpc_chk (.mclk_i, .rstn_i, .awvalid_i, .awready_o, .wvalid_i,
    .wready_o, .bvalid_o, .arvalid_i, .arready_o, .rvalid_o, .power_down_pin_i, .div_clk_o,
    .sample_o, .ref_int_en_o, .ref_ext_sel_o, .ref_buf_en_o, .bias_en_o, .int_clk_en_o,
    .out_oe_o, .dev_ready_o);

/* testbench/acdpc_board.sv */
// Board controller model driving the sync, power-down and sense pins
`timescale 1ns/100ps
module acdpc_board (
    // Clock and requests from the bench
    input wire mclk_i,
    input wire sync_req_i,
    input wire pd_req_i,
    input wire sense_req_i,
    // Pins toward the device
    output reg sync_o,
    output reg pd_pin_o,
    output reg sense_hi_o
);
    // Pins start low so the device never sees an unknown
    initial begin
        sync_o = 1'b0;
        pd_pin_o = 1'b0;
        sense_hi_o = 1'b0;
    end
    // Launched from the input clock so several devices realign on one edge
    always @(posedge mclk_i) begin
        sync_o <= sync_req_i;
        pd_pin_o <= pd_req_i;
        sense_hi_o <= sense_req_i;
    end
endmodule // acdpc_board

/* testbench/testbench.sv */
// Self-checking bench for the sample clock divider and power control block
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
    reg mclk_i = 1'b0;
    reg rstn_i = 1'b0;
    reg ce_i = 1'b1;
    reg [11:0] awaddr_i = 12'h000, araddr_i = 12'h000;
    reg [31:0] wdata_i = 32'h0;
    reg [3:0] wstrb_i = 4'hF;
    reg awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
    reg sync_req = 1'b0, pd_req = 1'b0, sense_req = 1'b0;
    wire sync_i, power_down_pin_i, sense_hi_i, awready_o, wready_o, bvalid_o, arready_o;
    wire rvalid_o, div_clk_o, sample_o, dcs_locked_o, ref_int_en_o, ref_ext_sel_o;
    wire ref_buf_en_o, bias_en_o, int_clk_en_o, out_oe_o, dev_ready_o;
    wire [1:0] bresp_o, rresp_o;
    wire [31:0] rdata_o;
    integer miscompares = 0;
    integer samples_checked = 0;
    integer n, h, w1, w2;
    reg [31:0] rd;
    reg [1:0] rsp;
    acdpc_top u_acdpc_top (.mclk_i, .rstn_i, .ce_i, .awaddr_i, .awvalid_i, .awready_o,
        .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i,
        .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i, .sync_i,
        .power_down_pin_i, .sense_hi_i, .div_clk_o, .sample_o, .dcs_locked_o, .ref_int_en_o,
        .ref_ext_sel_o, .ref_buf_en_o, .bias_en_o, .int_clk_en_o, .out_oe_o, .dev_ready_o);
    acdpc_board u_acdpc_board (.mclk_i, .sync_req_i(sync_req), .pd_req_i(pd_req),
        .sense_req_i(sense_req), .sync_o(sync_i), .pd_pin_o(power_down_pin_i),
        .sense_hi_o(sense_hi_i));
    always #5 mclk_i = ~mclk_i;
    // Write one word; address and data offered together, each dropped once taken
    task automatic axi_wr(input [11:0] a, input [31:0] d, output [1:0] r);
        integer k;
        reg busy;
        begin
            k = 0;
            busy = 1'b1;
            @(posedge mclk_i);
            awaddr_i <= a;
            wdata_i <= d;
            awvalid_i <= 1'b1;
            wvalid_i <= 1'b1;
            bready_i <= 1'b1;
            while (busy && k < 50) begin
                @(posedge mclk_i);
                k = k + 1;
                if (awready_o) awvalid_i <= 1'b0;
                if (wready_o) wvalid_i <= 1'b0;
                if (bvalid_o) begin
                    r = bresp_o;
                    bready_i <= 1'b0;
                    busy = 1'b0;
                end
            end
            if (busy) miscompares++;
        end
    endtask
    // Read one word; rready held until the data is seen
    task automatic axi_rd(input [11:0] a, output [31:0] d, output [1:0] r);
        integer k;
        reg busy;
        begin
            k = 0;
            busy = 1'b1;
            @(posedge mclk_i);
            araddr_i <= a;
            arvalid_i <= 1'b1;
            rready_i <= 1'b1;
            while (busy && k < 50) begin
                @(posedge mclk_i);
                k = k + 1;
                if (arready_o) arvalid_i <= 1'b0;
                if (rvalid_o) begin
                    d = rdata_o;
                    r = rresp_o;
                    rready_i <= 1'b0;
                    busy = 1'b0;
                end
            end
            if (busy) miscompares++;
        end
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        begin
            axi_wr(a, d, rsp);
            `CHK(rsp, 2'h0)
        end
    endtask
    // Period and high time between two strobes, sampled mid-cycle
    task automatic measure(output integer p, output integer hi);
        begin
            p = 0;
            hi = 0;
            @(negedge mclk_i);
            while (!sample_o) @(negedge mclk_i);
            do begin
                @(negedge mclk_i);
                p = p + 1;
                hi = hi + div_clk_o;
            end while (!sample_o && p < 20);
        end
    endtask
    task automatic t_regs;
        begin
            axi_rd(12'h000, rd, rsp);
            `CHK(rd, 32'h00000001)
            axi_rd(12'h100, rd, rsp);
            `CHK(rd, 32'h00000000)
            axi_rd(12'h010, rd, rsp);
            `CHK(rd & 32'h0000007E, 32'h00000020)
            axi_rd(12'h004, rd, rsp);
            `CHK({rd, rsp}, {32'h00000000, 2'h2})
            axi_wr(12'h004, 32'h00000001, rsp);
            `CHK(rsp, 2'h2)
            wr(12'h000, 32'h00000007);
            axi_rd(12'h000, rd, rsp);
            `CHK(rd, 32'h00000006)
            $display("register test done");
        end
    endtask
    // Every ratio with the stabilizer off, then on; a new setting lands at the next wrap
    task automatic t_ratio;
        integer r, s;
        begin
            for (s = 0; s < 2; s = s + 1) begin
                for (r = 1; r <= 6; r = r + 1) begin
                    wr(12'h000, r + 16 * s);
                    measure(n, h);
                    measure(n, h);
                    `CHK(n, r)
                    `CHK(h, (s && r <= 5) ? (r + 1) / 2 : 1)
                end
            end
            $display("ratio test done");
        end
    endtask
    task automatic t_lock;
        begin
            wr(12'h000, 32'h00000012);
            repeat (50) @(posedge mclk_i);
            `CHK(dcs_locked_o, 1'b0)
            repeat (200) @(posedge mclk_i);
            `CHK(dcs_locked_o, 1'b1)
            $display("lock test done");
        end
    endtask
    // Raise sync just after a strobe; the gap to the following strobe shows a restart
    task automatic sync_try(input integer exp);
        begin
            @(negedge mclk_i);
            while (!sample_o) @(negedge mclk_i);
            @(posedge mclk_i);
            sync_req <= 1'b1;
            measure(n, h);
            `CHK(n, exp)
            @(posedge mclk_i);
            sync_req <= 1'b0;
            repeat (8) @(posedge mclk_i);
        end
    endtask
    task automatic t_sync;
        begin
            wr(12'h000, 32'h00000006);
            measure(n, h);
            wr(12'h100, 32'h00000002);
            sync_try(1);
            sync_try(1);
            wr(12'h100, 32'h00000006);
            axi_rd(12'h010, rd, rsp);
            `CHK(rd[6], 1'b1)
            sync_try(1);
            sync_try(6);
            wr(12'h100, 32'h00000000);
            sync_try(6);
            $display("sync test done");
        end
    endtask
    task automatic wake_time(output integer c);
        begin
            c = 0;
            while (dev_ready_o !== 1'b1 && c < 1000) begin
                @(posedge mclk_i);
                c = c + 1;
            end
        end
    endtask
    // Hold the pin high for d cycles, then time the wake-up
    task automatic pin_down(input integer d, output integer c);
        begin
            @(posedge mclk_i);
            pd_req <= 1'b1;
            repeat (d) @(posedge mclk_i);
            `CHK({out_oe_o, int_clk_en_o, ref_buf_en_o, bias_en_o, ref_int_en_o}, 5'h00)
            pd_req <= 1'b0;
            wake_time(c);
        end
    endtask
    task automatic t_power;
        begin
            pin_down(40, w1);
            pin_down(400, w2);
            `CHK(w2 - w1, 45)
            wr(12'h008, 32'h00000001);
            repeat (8) @(posedge mclk_i);
            `CHK({out_oe_o, dev_ready_o}, 2'h0)
            axi_rd(12'h010, rd, rsp);
            `CHK(rd[3:2], 2'h2)
            wr(12'h008, 32'h00000000);
            wake_time(n);
            wr(12'h008, 32'h00000002);
            repeat (8) @(posedge mclk_i);
            `CHK({ref_int_en_o, ref_buf_en_o, bias_en_o, int_clk_en_o, out_oe_o}, 5'h1C)
            wr(12'h008, 32'h00000000);
            wake_time(n);
            `CHK(n < 12, 1'b1)
            sense_req <= 1'b1;
            repeat (8) @(posedge mclk_i);
            `CHK({ref_ext_sel_o, ref_int_en_o}, 2'h2)
            sense_req <= 1'b0;
            repeat (8) @(posedge mclk_i);
            `CHK({ref_ext_sel_o, ref_int_en_o}, 2'h1)
            $display("power test done");
        end
    endtask
    task end_of_test;
        begin
            $display("compares %0d mismatches %0d", samples_checked, miscompares);
            if (miscompares == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Main sequence after a four-cycle reset
    initial begin
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_regs;
        t_ratio;
        t_lock;
        t_sync;
        t_power;
        end_of_test;
    end
    // Watchdog well beyond the few thousand cycles the tests need
    initial begin
        #200000;
        miscompares++;
        end_of_test;
    end
endmodule // testbench
